// *** rtl/baud_tick.sv ***
/*
 Baud divider: one-cycle enable pulse at the oversample rate.
 Assumes divisor is reloaded whenever software changes it.
*/
`timescale 1ns/1ps
`default_nettype none
module baud_tick #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] divisor_i,
   output logic tick_o
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic tick;
   } tick_state_t;
   tick_state_t s_r;
   tick_state_t s_nxt;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.count >= divisor_i)
      begin
         s_nxt.count = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.count = s_r.count + 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign tick_o = s_r.tick;
endmodule : baud_tick
`default_nettype wire

// *** rtl/uart_receive_status.sv ***
/*
 UART receiver with status register, receive FIFO and per-character error flags.
 Assumes the receive line is already synchronous to clk_sys_i and idles high.
// Overview of operation
// RL1: Ninth-bit-one characters are addresses when enabled
// RL2: Idle flag high while no reception active
// RL3: Parity error flag follows FIFO head
// RL4: Framing error flag follows FIFO head
// RL5: Overrun set by hardware, software only clears
// RL6: Clearing overrun empties FIFO and shift register
// RL7: Data available while FIFO not empty
// RL8: Discard incoming characters while overrun set
*/
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart_receive_status #(
   parameter int DEPTH = uart_rx_pkg::FIFO_DEPTH,
   parameter int PTR_W = $clog2(DEPTH)
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic rx_line_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic address_char_o
);
   localparam int CW = uart_rx_pkg::CHAR_WIDTH;
   localparam int EW = CW + 2;
   typedef struct packed {
      uart_rx_pkg::rx_state_t state;
      logic [3:0] sub;
      logic [3:0] bitn;
      logic [CW:0] receive_shift_register;
      logic address_detect_enable;
      logic overrun_error_flag;
      logic [1:0] parity_mode;
      logic nine_bit;
      logic [15:0] divisor;
      logic [PTR_W:0] wptr;
      logic [PTR_W:0] rptr;
      logic [15:0] rdata;
      logic address_char;
   } rx_regs_t;
   rx_regs_t s_r;
   rx_regs_t s_nxt;
   logic [EW-1:0] fifo_mem [DEPTH];
   logic [EW-1:0] head;
   logic tick;
   logic empty;
   logic full;
   logic [3:0] nbits;
   logic par_calc;
   logic par_bad;
   logic push;
   logic pop;
   logic [EW-1:0] entry;
   baud_tick #(
      .WIDTH(16)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .divisor_i(s_r.divisor),
      .tick_o(tick)
   );
   assign empty = (s_r.wptr == s_r.rptr);
   assign full = (s_r.wptr[PTR_W] != s_r.rptr[PTR_W])
      && (s_r.wptr[PTR_W-1:0] == s_r.rptr[PTR_W-1:0]);
   assign head = fifo_mem[s_r.rptr[PTR_W-1:0]];
   always_comb
   begin
      nbits = 4'h8;
      if (s_r.nine_bit)
         nbits = 4'h9;
      else if (s_r.parity_mode != uart_rx_pkg::PARITY_NONE)
         nbits = 4'h9;
   end
   // Received bits sit at the top of the shift register, LSB first
   always_comb
   begin
      par_calc = ^s_r.receive_shift_register[CW:1];
      par_bad = 1'b0;
      if (!s_r.nine_bit && s_r.parity_mode == uart_rx_pkg::PARITY_EVEN)
         par_bad = par_calc;
      else if (!s_r.nine_bit && s_r.parity_mode == uart_rx_pkg::PARITY_ODD)
         par_bad = !par_calc;
   end
   always_comb
   begin
      s_nxt = s_r;
      push = 1'b0;
      pop = 1'b0;
      entry = '0;
      s_nxt.address_char = 1'b0;
      if (tick)
      begin
         case (s_r.state)
            uart_rx_pkg::RX_IDLE:
            begin
               if (!rx_line_i)
               begin
                  s_nxt.state = uart_rx_pkg::RX_START;
                  s_nxt.sub = '0;
               end
            end
            uart_rx_pkg::RX_START:
            begin
               s_nxt.sub = s_r.sub + 1'b1;
               if (s_r.sub == 4'(uart_rx_pkg::MID_SAMPLE))
               begin
                  if (rx_line_i)
                     s_nxt.state = uart_rx_pkg::RX_IDLE;
                  else
                  begin
                     s_nxt.state = uart_rx_pkg::RX_DATA;
                     s_nxt.sub = '0;
                     s_nxt.bitn = '0;
                  end
               end
            end
            uart_rx_pkg::RX_DATA:
            begin
               s_nxt.sub = s_r.sub + 1'b1;
               if (s_r.sub == 4'(uart_rx_pkg::OVERSAMPLE - 1))
               begin
                  s_nxt.receive_shift_register = {rx_line_i, s_r.receive_shift_register[CW:1]};
                  s_nxt.bitn = s_r.bitn + 1'b1;
                  if (s_r.bitn == nbits - 1'b1)
                     s_nxt.state = uart_rx_pkg::RX_STOP;
               end
            end
            uart_rx_pkg::RX_STOP:
            begin
               s_nxt.sub = s_r.sub + 1'b1;
               if (s_r.sub == 4'(uart_rx_pkg::OVERSAMPLE - 1))
               begin
                  s_nxt.state = uart_rx_pkg::RX_IDLE;
                  // Align character to bit 0 for 8-bit frames
                  entry[CW-1:0] = (nbits == 4'h9) ? s_r.receive_shift_register[CW:1]
                     : {1'b0, s_r.receive_shift_register[CW:2]};
                  if (!s_r.nine_bit)
                     entry[CW-1] = 1'b0;
                  entry[CW] = !rx_line_i; // RL4
                  entry[CW+1] = par_bad; // RL3
                  if (s_r.nine_bit && s_r.address_detect_enable)
                     s_nxt.address_char = s_r.receive_shift_register[CW]; // RL1
                  if (s_r.overrun_error_flag)
                     push = 1'b0; // RL8
                  else if (full)
                     s_nxt.overrun_error_flag = 1'b1; // RL5
                  else
                     push = 1'b1;
               end
            end
            default:
               s_nxt.state = uart_rx_pkg::RX_IDLE;
         endcase
      end
      if (push)
         s_nxt.wptr = s_r.wptr + 1'b1;
      s_nxt.rdata = '0;
      if (rd_i)
      begin
         case (addr_i)
            uart_rx_pkg::STATUS_CONTROL_OFFSET:
            begin
               s_nxt.rdata[uart_rx_pkg::ADDRESS_DETECT_BIT] = s_r.address_detect_enable;
               s_nxt.rdata[uart_rx_pkg::RECEIVER_IDLE_BIT] =
                  (s_r.state == uart_rx_pkg::RX_IDLE); // RL2
               s_nxt.rdata[uart_rx_pkg::PARITY_ERROR_BIT] = !empty && head[CW+1]; // RL3
               s_nxt.rdata[uart_rx_pkg::FRAMING_ERROR_BIT] = !empty && head[CW]; // RL4
               s_nxt.rdata[uart_rx_pkg::OVERRUN_BIT] = s_r.overrun_error_flag;
               s_nxt.rdata[uart_rx_pkg::DATA_AVAILABLE_BIT] = !empty; // RL7
            end
            uart_rx_pkg::RX_DATA_OFFSET:
            begin
               s_nxt.rdata[CW-1:0] = empty ? '0 : head[CW-1:0];
               pop = !empty;
            end
            uart_rx_pkg::MODE_CONTROL_OFFSET:
               s_nxt.rdata[2:0] = {s_r.nine_bit, s_r.parity_mode};
            uart_rx_pkg::BAUD_DIVISOR_OFFSET:
               s_nxt.rdata = s_r.divisor;
            default:
               s_nxt.rdata = '0;
         endcase
      end
      if (pop)
         s_nxt.rptr = s_r.rptr + 1'b1;
      if (wr_i)
      begin
         case (addr_i)
            uart_rx_pkg::STATUS_CONTROL_OFFSET:
            begin
               s_nxt.address_detect_enable = wdata_i[uart_rx_pkg::ADDRESS_DETECT_BIT];
               // Software can only clear; no overrun is raised while the flag is up,
               // so a clear is never lost to a character finishing in the same cycle
               if (s_r.overrun_error_flag && !wdata_i[uart_rx_pkg::OVERRUN_BIT])
               begin
                  s_nxt.overrun_error_flag = 1'b0; // RL5
                  s_nxt.rptr = s_r.wptr; // RL6
                  s_nxt.receive_shift_register = '0; // RL6
                  s_nxt.state = uart_rx_pkg::RX_IDLE; // RL6
                  s_nxt.sub = '0;
                  s_nxt.bitn = '0;
               end
            end
            uart_rx_pkg::MODE_CONTROL_OFFSET:
            begin
               s_nxt.parity_mode = wdata_i[1:0];
               s_nxt.nine_bit = wdata_i[uart_rx_pkg::MODE_NINE_BIT];
            end
            uart_rx_pkg::BAUD_DIVISOR_OFFSET:
               s_nxt.divisor = wdata_i;
            default:
               s_nxt.divisor = s_r.divisor;
         endcase
      end
   end
   // Storage kept out of the reset path; pointers guard its contents
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         fifo_mem[s_r.wptr[PTR_W-1:0]] <= entry;
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         s_r <= '0;
         s_r.state <= uart_rx_pkg::RX_IDLE;
         s_r.divisor <= uart_rx_pkg::BAUD_DIVISOR_RESET;
         s_r.parity_mode <= uart_rx_pkg::MODE_RESET;
      end
      else
         s_r <= s_nxt;
   end
   assign rdata_o = s_r.rdata;
   assign address_char_o = s_r.address_char;
endmodule : uart_receive_status
`default_nettype wire

// *** shared/uart_rx_pkg.sv ***
/*
 Package for the UART receive-status block: register offset, field positions,
 reset values and timing. Assumes a 50 MHz system clock.
*/
package uart_rx_pkg;
   localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
   localparam logic [3:0] RX_DATA_OFFSET = 4'h2;
   localparam logic [3:0] MODE_CONTROL_OFFSET = 4'h4;
   localparam logic [3:0] BAUD_DIVISOR_OFFSET = 4'h6;
   localparam int ADDRESS_DETECT_BIT = 5;
   localparam int RECEIVER_IDLE_BIT = 4;
   localparam int PARITY_ERROR_BIT = 3;
   localparam int FRAMING_ERROR_BIT = 2;
   localparam int OVERRUN_BIT = 1;
   localparam int DATA_AVAILABLE_BIT = 0;
   localparam int MODE_PARITY_LSB = 0;
   localparam int MODE_NINE_BIT = 2;
   localparam logic [15:0] BAUD_DIVISOR_RESET = 16'h001a;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam int OVERSAMPLE = 16;
   localparam int MID_SAMPLE = 7;
   localparam int FIFO_DEPTH = 4;
   localparam int CHAR_WIDTH = 9;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b11,
      RX_STOP = 2'b10
   } rx_state_t;
   typedef enum logic [1:0] {
      PARITY_NONE = 2'b00,
      PARITY_EVEN = 2'b01,
      PARITY_ODD = 2'b10
   } parity_mode_t;
endpackage : uart_rx_pkg

// *** tb/serial_tx_model.sv ***
/* Remote transmitter: sends start bit then 12 frame bits, LSB first.
   Assumes BIT_CLKS matches the receiver bit time. */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_sys_i,
   input wire logic go_i,
   input wire logic [11:0] frame_i,
   output logic line_o,
   output logic busy_o
);
   // Ones shift in, so the line idles high between frames
   logic [12:0] sh_r = 13'h1fff;
   int cnt_r = 0;
   int left_r = 0;
   assign line_o = sh_r[0];
   assign busy_o = left_r != 0;
   always @(posedge clk_sys_i)
   begin
      if (go_i && !busy_o)
      begin
         sh_r <= {frame_i, 1'b0};
         left_r <= 13;
         cnt_r <= BIT_CLKS - 1;
      end
      else if (busy_o && cnt_r == 0)
      begin
         sh_r <= {1'b1, sh_r[12:1]};
         left_r <= left_r - 1;
         cnt_r <= BIT_CLKS - 1;
      end
      else if (busy_o)
         cnt_r <= cnt_r - 1;
   end
endmodule : serial_tx_model
`default_nettype wire

// *** tb/tb_top.sv ***
/* Bench for uart_receive_status: bus tasks and scenarios.
   Assumes serial_tx_model drives the receive line. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_n_i, wr_i, rd_i, go, line, busy, address_char_o;
   logic [3:0] addr_i;
   logic [15:0] wdata_i, rdata_o;
   logic [11:0] frame;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int n_addr = 0;
   always #10 clk_sys_i = ~clk_sys_i;
   uart_receive_status uart_receive_status_inst (.clk_sys_i, .rst_n_i, .rx_line_i(line),
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .address_char_o);
   serial_tx_model serial_tx_model_inst (.clk_sys_i, .go_i(go), .frame_i(frame),
      .line_o(line), .busy_o(busy));
   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Strobes rise on one edge and fall on the next; read data is taken 1 ns later
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk("rdata", rdata_o, e);
   endtask : rd
   task automatic launch(logic [11:0] f);
      frame <= f;
      go <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      #1;
   endtask : launch
   task automatic send(logic [11:0] f);
      launch(f);
      while (busy)
      begin
         @(posedge clk_sys_i);
         #1;
      end
   endtask : send
   task automatic fill();
      for (int i = 0; i < 5; i++)
         send({4'hf, 8'h10 + 8'(i)});
   endtask : fill
   always @(posedge clk_sys_i)
   begin
      cycles <= cycles + 1;
      if (address_char_o === 1'b1)
         n_addr <= n_addr + 1;
      if (cycles == 20000)
      begin
         n_errors = n_errors + 1;
         close_out();
      end
   end
   initial
   begin
      rst_n_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 16'h0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      go = 1'b0;
      frame = 12'hfff;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      #1;
      rd(4'h0, 16'h0010);
      rd(4'h2, 16'h0000);
      rd(4'h9, 16'h0000);
      rd(4'h6, 16'h001a);
      wr(4'h6, 16'h0000);
      rd(4'h6, 16'h0000);
      launch(12'hfa5);
      repeat (40) @(posedge clk_sys_i);
      #1;
      rd(4'h0, 16'h0000);
      send(12'hfff);
      rd(4'h0, 16'h0011);
      rd(4'h2, 16'h00a5);
      rd(4'h0, 16'h0010);
      send(12'hea5);
      rd(4'h0, 16'h0015);
      rd(4'h2, 16'h00a5);
      rd(4'h0, 16'h0010);
      wr(4'h4, 16'h0001);
      send(12'he01);
      rd(4'h0, 16'h0019);
      rd(4'h2, 16'h0001);
      send(12'hf01);
      rd(4'h0, 16'h0011);
      rd(4'h2, 16'h0001);
      wr(4'h4, 16'h0002);
      send(12'hf01);
      rd(4'h0, 16'h0019);
      rd(4'h2, 16'h0001);
      wr(4'h4, 16'h0004);
      rd(4'h4, 16'h0004);
      wr(4'h0, 16'h0020);
      send(12'hfa5);
      chk("addr pulses", 16'(n_addr), 16'h0001);
      rd(4'h0, 16'h0031);
      rd(4'h2, 16'h01a5);
      wr(4'h0, 16'h0000);
      send(12'hfa5);
      rd(4'h2, 16'h01a5);
      wr(4'h4, 16'h0000);
      wr(4'h0, 16'h0020);
      send(12'hfa5);
      chk("addr pulses", 16'(n_addr), 16'h0001);
      rd(4'h2, 16'h00a5);
      wr(4'h0, 16'h0000);
      fill();
      rd(4'h0, 16'h0013);
      rd(4'h2, 16'h0010);
      send(12'hf77);
      rd(4'h2, 16'h0011);
      rd(4'h2, 16'h0012);
      rd(4'h2, 16'h0013);
      rd(4'h0, 16'h0012);
      rd(4'h2, 16'h0000);
      wr(4'h0, 16'h0002);
      rd(4'h0, 16'h0012);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0010);
      fill();
      rd(4'h0, 16'h0013);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0010);
      rd(4'h2, 16'h0000);
      close_out();
   end
endmodule : tb_top
`default_nettype wire

// *** tb/uart_rx_sva.sv ***
/* Checker on the uart_receive_status ports.
   Assumes a master with one-cycle strobes, never both at once. */
`timescale 1ns/1ps
`default_nettype none
module uart_rx_sva #(
   parameter int DEPTH = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic rx_line_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic address_char_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic aden_r, nine_r, ov_r, rs_r, emp_r;
   wire logic st_rd = rd_i && addr_i == 4'h0;
   wire logic dat_rd = rd_i && addr_i == 4'h2;
   // Mirrors of software-visible state, kept from the bus alone
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         aden_r <= 1'b0;
         nine_r <= 1'b0;
         ov_r <= 1'b0;
         rs_r <= 1'b0;
         emp_r <= 1'b0;
      end
      else
      begin
         rs_r <= st_rd;
         if (wr_i && addr_i == 4'h0)
            aden_r <= wdata_i[5];
         if (wr_i && addr_i == 4'h4)
            nine_r <= wdata_i[2];
         if (rs_r)
         begin
            ov_r <= rdata_o[1];
            emp_r <= !rdata_o[0];
         end
      end
   end
   sequence s_clear_ov;
      wr_i && addr_i == 4'h0 && !wdata_i[1] && ov_r;
   endsequence
   sequence s_status_rd;
      st_rd;
   endsequence
   a_rdata_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("rdata not zero without read");
   a_unmapped_zero: assert property (rd_i && (addr_i[0] || addr_i[3]) |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_parity_error_flag_head: assert property (st_rd |=> rdata_o[0] || !rdata_o[3])
      else $error("parity flag with empty fifo");
   a_framing_error_flag_head: assert property (st_rd |=> rdata_o[0] || !rdata_o[2])
      else $error("framing flag with empty fifo");
   a_addr_pulse: assert property (address_char_o |=> !address_char_o)
      else $error("address pulse too long");
   a_addr_mode: assert property (address_char_o |-> aden_r && nine_r)
      else $error("address pulse outside enabled nine-bit mode");
   a_aden_back: assert property (st_rd |=> rdata_o[5] == aden_r)
      else $error("address enable readback wrong");
   a_clear_empties: assert property (s_clear_ov ##[1:2] s_status_rd
      |=> rdata_o[1:0] == 2'b00)
      else $error("overrun clear left data");
   a_empty_pop: assert property (dat_rd && $past(rs_r) && emp_r |=> rdata_o == 16'h0000)
      else $error("data read from empty fifo");
endmodule : uart_rx_sva
bind uart_receive_status uart_rx_sva #(.DEPTH(DEPTH)) uart_rx_sva_inst (.clk_sys_i, .rst_n_i,
   .rx_line_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .address_char_o);
`default_nettype wire
